// ---- rtl/fsp_ctrl.sv ----
// Sector flash program, erase and read-out protection controller.
// Assumes the array acknowledges each command with a one-cycle done pulse.
module fsp_ctrl
	import fsp_pkg::*;
(
	// Clock and reset
	input  wire logic      clock,
	input  wire logic      nrst,
	// Configuration
	input  wire fsp_mode_t mode,
	input  wire fsp_size_t array_size,
	input  wire logic      readout_protect_option_bit,
	// Guard key port
	input  wire logic      key_valid,
	input  wire logic [7:0] key_data,
	// Request port
	input  wire fsp_cmd_t  req,
	output logic           req_ready_r,
	output logic           done_r,
	output logic           refused_r,
	// Read port
	input  wire logic      rd_req,
	input  wire logic [15:0] rd_addr,
	output logic           rd_valid_r,
	output logic           rd_blocked_r,
	output logic [7:0]     rd_data_r,
	// Array side
	output fsp_cmd_t       arr_cmd_r,
	output logic           arr_rd_r,
	output logic [15:0]    arr_rd_addr_r,
	input  wire logic      arr_done,
	input  wire logic [7:0] arr_rdata,
	// Status
	output logic           protect_r,
	output logic           guard_armed_r
);

	// ****************************************
	// Decoding
	// ****************************************
	// Returns {valid, index}; lower sectors are only present on larger arrays.
	function automatic logic [2:0] sector_of(input logic [15:0] a, input fsp_size_t s);
		logic [2:0] r;
		r = 3'h0;
		if (a >= SECT0_BASE) begin
			r = {1'b1, 2'd0};
		end else if (a >= SECT1_BASE) begin
			r = {(s != SIZE_4K), 2'd1};
		end else begin
			r = {(s == SIZE_LARGE), 2'd2};
		end
		return r;
	endfunction

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUSY,
		ST_WIPE,
		ST_OPTWRITE
	} fsp_state_t;

	fsp_state_t state_r;
	logic       loaded_r;
	logic       key1_seen_r;
	logic       take;
	logic       permit;
	logic       unprotect;
	logic [2:0] sect;
	logic       ext_read;

	assign take = req.valid && req_ready_r;
	assign sect = sector_of(req.addr, array_size);
	assign unprotect = (req.op == OP_OPTION) && protect_r && !req.data[OPT_PROT_BIT];
	assign ext_read = protect_r && (mode != MODE_IAP);

	// A request passes only when armed and permitted by mode and protection; program and sector erase must also be in range.
	always_comb begin
		permit = guard_armed_r;
		unique case (req.op)
			OP_PROG, OP_ERASE_SECT: begin
				permit = permit && sect[2] && !protect_r;
				if (mode == MODE_IAP && sect[1:0] == 2'd0) begin
					permit = 1'b0;
				end
			end
			OP_ERASE_ALL: begin
				// Erasing everything would take out the boot sector as well.
				permit = permit && !protect_r && (mode != MODE_IAP);
			end
			OP_OPTION: begin
				permit = permit && (mode != MODE_IAP);
			end
		endcase
	end

	// ****************************************
	// Guard key sequence
	// ****************************************
	// Any wrong key drops the sequence; a taken request consumes the arm unless the sequence completes in that cycle.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			key1_seen_r   <= 1'b0;
			guard_armed_r <= 1'b0;
		end else begin
			if (key_valid) begin
				key1_seen_r <= (key_data == GUARD_KEY1);
			end
			if (key_valid && key1_seen_r && key_data == GUARD_KEY2) begin
				// A sequence that completes as a request is taken arms the next request.
				guard_armed_r <= 1'b1;
			end else if (take) begin
				guard_armed_r <= 1'b0;
			end else if (key_valid) begin
				guard_armed_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Protection state
	// ****************************************
	// The nonvolatile bit is caught one clock after reset release.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			loaded_r  <= 1'b0;
			protect_r <= PROTECT_RST;
		end else begin
			loaded_r <= 1'b1;
			if (!loaded_r) begin
				protect_r <= readout_protect_option_bit;
			end else if (arr_done && arr_cmd_r.op == OP_OPTION && arr_cmd_r.valid) begin
				protect_r <= arr_cmd_r.data[OPT_PROT_BIT];
			end
		end
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r     <= ST_IDLE;
			req_ready_r <= 1'b0;
			done_r      <= 1'b0;
			refused_r   <= 1'b0;
			arr_cmd_r   <= '0;
		end else begin
			done_r    <= 1'b0;
			refused_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					req_ready_r <= loaded_r;
					if (take) begin
						req_ready_r <= 1'b0;
						if (!permit) begin
							refused_r   <= 1'b1;
							req_ready_r <= 1'b1;
						end else if (unprotect) begin
							// Wipe first so protected code is never exposed.
							arr_cmd_r <= '{1'b1, OP_ERASE_ALL, 16'h0000, 8'h00};
							state_r   <= ST_WIPE;
						end else begin
							// The request goes to the array as given: op, address and data unchanged.
							arr_cmd_r <= '{1'b1, req.op, req.addr, req.data};
							state_r   <= ST_BUSY;
						end
					end
				end
				ST_WIPE: begin
					if (arr_done) begin
						arr_cmd_r <= '{1'b1, OP_OPTION, 16'h0000, 8'h00};
						state_r   <= ST_OPTWRITE;
					end
				end
				ST_BUSY, ST_OPTWRITE: begin
					if (arr_done) begin
						arr_cmd_r   <= '0;
						done_r      <= 1'b1;
						req_ready_r <= 1'b1;
						state_r     <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// External readers see zeros under protection; the array is not even read.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			arr_rd_r      <= 1'b0;
			arr_rd_addr_r <= 16'h0000;
			rd_valid_r    <= 1'b0;
			rd_blocked_r  <= 1'b0;
			rd_data_r     <= 8'h00;
		end else begin
			arr_rd_r      <= rd_req && !ext_read;
			arr_rd_addr_r <= rd_addr;
			rd_valid_r    <= arr_rd_r;
			rd_data_r     <= arr_rd_r ? arr_rdata : 8'h00;
			if (rd_req) begin
				rd_blocked_r <= ext_read;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_take_ok;
		take && permit;
	endsequence

	sequence s_unprotect_take;
		take && permit && unprotect;
	endsequence

	chk_guard_unarmed: assert property (@(posedge clock) disable iff (!nrst)
		take && !guard_armed_r |=> refused_r && !arr_cmd_r.valid)
		else $error("unarmed request was not refused");

	chk_iap_boot_sector: assert property (@(posedge clock) disable iff (!nrst)
		take && mode == MODE_IAP && req.op != OP_OPTION && req.addr >= SECT0_BASE
		|=> refused_r)
		else $error("application mode reached the boot sector");

	chk_protect_write: assert property (@(posedge clock) disable iff (!nrst)
		take && protect_r && req.op inside {OP_PROG, OP_ERASE_SECT, OP_ERASE_ALL}
		|=> refused_r)
		else $error("write passed under read-out protection");

	chk_prog_single_byte: assert property (@(posedge clock) disable iff (!nrst)
		s_take_ok ##0 (req.op == OP_PROG) |=> arr_cmd_r.valid && arr_cmd_r.op == OP_PROG
		&& arr_cmd_r.addr == $past(req.addr) && arr_cmd_r.data == $past(req.data))
		else $error("program command differs from request");

	chk_wipe_before_clear: assert property (@(posedge clock) disable iff (!nrst)
		s_unprotect_take |=> arr_cmd_r.valid && arr_cmd_r.op == OP_ERASE_ALL
		&& protect_r)
		else $error("protection removal did not start with full erase");

	chk_refused_quiet: assert property (@(posedge clock) disable iff (!nrst)
		take && !permit |=> !arr_cmd_r.valid [*2])
		else $error("refused request reached the array");

	chk_sector_in_range: assert property (@(posedge clock) disable iff (!nrst)
		arr_cmd_r.valid && arr_cmd_r.op inside {OP_PROG, OP_ERASE_SECT}
		|-> sector_of(arr_cmd_r.addr, array_size) >= 3'h4)
		else $error("array command outside present sectors");

	chk_small_array: assert property (@(posedge clock) disable iff (!nrst)
		take && array_size == SIZE_4K && req.op == OP_PROG && req.addr < SECT0_BASE
		|=> refused_r)
		else $error("absent sector accepted on 4K array");

	chk_read_blocked: assert property (@(posedge clock) disable iff (!nrst)
		rd_req && ext_read |=> rd_blocked_r && !arr_rd_r ##1 rd_data_r == 8'h00)
		else $error("protected contents were read out");

	chk_tool_full_access: assert property (@(posedge clock) disable iff (!nrst)
		take && guard_armed_r && !protect_r && mode != MODE_IAP && sect[2]
		&& req.op == OP_PROG |=> !refused_r && arr_cmd_r.valid)
		else $error("external mode was denied a sector");

	chk_protect_source: assert property (@(posedge clock) disable iff (!nrst)
		$past(loaded_r) && $changed(protect_r) |-> $past(arr_done)
		&& $past(arr_cmd_r.op) == OP_OPTION)
		else $error("protection changed without option write");

	chk_guard_consumed: assert property (@(posedge clock) disable iff (!nrst)
		take && !(key_valid && key1_seen_r && key_data == GUARD_KEY2)
		|=> !guard_armed_r)
		else $error("guard stayed armed after a request");

	chk_iap_erase_all: assert property (@(posedge clock) disable iff (!nrst)
		take && mode == MODE_IAP && req.op inside {OP_ERASE_ALL, OP_OPTION}
		|=> refused_r)
		else $error("application mode erased all or wrote options");

	chk_clear_after_wipe: assert property (@(posedge clock) disable iff (!nrst)
		state_r == ST_OPTWRITE && arr_done |=> !protect_r && done_r)
		else $error("protection not cleared after the wipe");

endmodule // fsp_ctrl

// ---- rtl/fsp_pkg.sv ----
// Shared types and constants of the sector flash program and protect controller.
// Assumes a 16-bit CPU address space with the flash array at its top.
package fsp_pkg;

	// ****************************************
	// Address map and sizes
	// ****************************************
	localparam logic [15:0] SECT0_BASE = 16'hF000;
	localparam logic [15:0] SECT1_BASE = 16'hE000;
	localparam logic [15:0] SIZE_8K_BASE = 16'hE000;
	localparam int unsigned SECTOR_BYTES = 4096;

	// ****************************************
	// Guard keys and option layout
	// ****************************************
	// Key values are arbitrary.
	localparam logic [7:0] GUARD_KEY1 = 8'h5A;
	localparam logic [7:0] GUARD_KEY2 = 8'hC3;
	localparam int unsigned OPT_PROT_BIT = 0;
	localparam logic PROTECT_RST = 1'b0;

	typedef enum logic [1:0] {
		MODE_TOOL,
		MODE_ICP,
		MODE_IAP
	} fsp_mode_t;

	typedef enum logic [1:0] {
		SIZE_4K,
		SIZE_8K,
		SIZE_LARGE
	} fsp_size_t;

	typedef enum logic [1:0] {
		OP_PROG,
		OP_ERASE_SECT,
		OP_ERASE_ALL,
		OP_OPTION
	} fsp_op_t;

	typedef struct packed {
		logic        valid;
		fsp_op_t     op;
		logic [15:0] addr;
		logic [7:0]  data;
	} fsp_cmd_t;

endpackage : fsp_pkg

// ---- testbench/fsp_arr_model.sv ----
// Behavioural flash array facing the controller's array port.
// Assumes each command stays valid until its one-cycle done pulse is seen.
module fsp_arr_model
	import fsp_pkg::*;
(
	// Clock and pacing
	input  wire logic        clock,
	input  wire logic        slow,
	// Array port
	input  wire fsp_cmd_t    cmd,
	input  wire logic        rd,
	input  wire logic [15:0] rd_addr,
	output logic             done,
	output logic [7:0]       rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int];
	logic [7:0] held = 8'h00;
	logic       done_q = 1'b0;
	int         n = 0;
	int         lo;
	int         hi;
	function automatic logic [7:0] rdb(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction
	// Between reads the data lines toggle, so a stale byte is never mistaken for data.
	assign rdata = rd ? rdb(rd_addr) : held;
	assign done = done_q;
	always @(posedge clock) begin
		held <= rd ? rdb(rd_addr) : ~held;
		done_q <= 1'b0;
		if (cmd.valid && !done_q) begin
			n <= n + 1;
			if (n >= (slow ? 4 : 0)) begin
				n <= 0;
				done_q <= 1'b1;
				if (cmd.op == OP_PROG) mem[cmd.addr] = cmd.data;
				if (cmd.op == OP_ERASE_ALL) mem.delete();
				if (cmd.op == OP_ERASE_SECT) begin
					lo = cmd.addr[15:13] == 3'b111 ? {cmd.addr[15:12], 12'h000} : 0;
					hi = cmd.addr[15:13] == 3'b111 ? lo + 4095 : 16'hDFFF;
					for (int a = lo; a <= hi; a++) mem.delete(a);
				end
			end
		end
	end
endmodule // fsp_arr_model

// ---- testbench/tb.sv ----
// Self-checking bench of the sector flash program and protect controller.
// Assumes the array model is compiled first; inputs change at falling edges.
module tb import fsp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic        kv = 1'b0;
	logic        rq = 1'b0;
	logic        slow = 1'b0;
	logic        opt = 1'b0;
	logic [7:0]  kd = 8'h00;
	logic [15:0] ra = 16'h0000;
	fsp_mode_t   mode = MODE_TOOL;
	fsp_size_t   size = SIZE_LARGE;
	fsp_cmd_t    req = '0;
	fsp_cmd_t    acmd;
	logic        rdy, dn, rf, rv, bk, ard, adn, prot, arm;
	logic [7:0]  rdat, ardat;
	logic [15:0] aadr;
	logic [9:0]  expq [$];
	logic [31:0] seed = 32'h0000_0003;
	logic [15:0] a [3];
	logic [7:0]  d [3];
	int          err_count = 0;
	int          n_tests = 0;
	always #4 clock = ~clock;
	fsp_ctrl dut_u (.clock(clock), .nrst(nrst), .mode(mode), .array_size(size),
		.readout_protect_option_bit(opt), .key_valid(kv), .key_data(kd), .req(req),
		.req_ready_r(rdy), .done_r(dn), .refused_r(rf), .rd_req(rq), .rd_addr(ra),
		.rd_valid_r(rv), .rd_blocked_r(bk), .rd_data_r(rdat), .arr_cmd_r(acmd),
		.arr_rd_r(ard), .arr_rd_addr_r(aadr), .arr_done(adn), .arr_rdata(ardat),
		.protect_r(prot), .guard_armed_r(arm));
	fsp_arr_model arr_u (.clock(clock), .slow(slow), .cmd(acmd), .rd(ard),
		.rd_addr(aadr), .done(adn), .rdata(ardat));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (err_count == 0 && n_tests > 0 && expq.size() == 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Expected answer kinds: 0 done, 1 refused, 2 read data.
	task automatic cmd(input fsp_op_t op, input logic [15:0] ad, input logic [7:0] dt,
		input logic keys, input logic [1:0] k);
		int n;
		n = 0;
		if (keys) begin
			kv = 1'b1;
			kd = GUARD_KEY1;
			@(negedge clock);
			kd = GUARD_KEY2;
			@(negedge clock);
			kv = 1'b0;
			check({9'h000, arm}, 10'h001);
		end
		expq.push_back({k, 8'h00});
		req = {1'b1, op, ad, dt};
		while (rdy !== 1'b1 && n < 50) begin
			n++;
			@(negedge clock);
		end
		if (rdy !== 1'b1) err_count++;
		// Ready seen at a falling edge means the next rising edge takes the request.
		@(negedge clock);
		req = '0;
		n = 0;
		while (dn !== 1'b1 && rf !== 1'b1 && n < 500) begin
			n++;
			@(negedge clock);
		end
		if (n >= 500) err_count++;
		@(negedge clock);
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] dt, input logic blk);
		rq = 1'b1;
		ra = ad;
		if (!blk) expq.push_back({2'd2, dt});
		@(negedge clock);
		rq = 1'b0;
		repeat (2) @(negedge clock);
		check({9'h000, bk}, {9'h000, blk});
	endtask
	always @(negedge clock) begin
		if (nrst && (dn || rf || rv))
			check({rv, rf, rv ? rdat : 8'h00}, expq.size() ? expq.pop_front() : 10'h3FF);
	end
	initial begin
		repeat (6) @(negedge clock);
		nrst = 1'b1;
		repeat (3) @(negedge clock);
		for (int s = 0; s < 3; s++) begin
			a[s] = (s == 0 ? 16'hF000 : s == 1 ? 16'hE000 : 16'h1000) | {4'h0, rnd(), 4'h0};
			d[s] = rnd();
			cmd(OP_PROG, a[s], d[s], 1'b1, 2'd0);
			rd(a[s], d[s], 1'b0);
		end
		slow = 1'b1;
		cmd(OP_ERASE_SECT, a[1], 8'h00, 1'b1, 2'd0);
		rd(a[1], 8'hFF, 1'b0);
		rd(a[0], d[0], 1'b0);
		cmd(OP_PROG, a[1], d[1], 1'b0, 2'd1);
		mode = MODE_ICP;
		cmd(OP_PROG, a[1], d[1], 1'b1, 2'd0);
		mode = MODE_IAP;
		cmd(OP_PROG, 16'hFFFE, 8'h00, 1'b1, 2'd1);
		cmd(OP_ERASE_ALL, 16'h0000, 8'h00, 1'b1, 2'd1);
		cmd(OP_ERASE_SECT, a[2], 8'h00, 1'b1, 2'd0);
		rd(a[0], d[0], 1'b0);
		rd(a[1], d[1], 1'b0);
		mode = MODE_TOOL;
		size = SIZE_8K;
		cmd(OP_PROG, a[2], 8'h00, 1'b1, 2'd1);
		size = SIZE_4K;
		cmd(OP_PROG, a[1], 8'h00, 1'b1, 2'd1);
		size = SIZE_LARGE;
		cmd(OP_OPTION, 16'h0000, 8'h01, 1'b1, 2'd0);
		check({9'h000, prot}, 10'h001);
		rd(a[0], 8'h00, 1'b1);
		cmd(OP_PROG, a[0], 8'h00, 1'b1, 2'd1);
		cmd(OP_OPTION, 16'h0000, 8'h00, 1'b1, 2'd0);
		rd(a[0], 8'hFF, 1'b0);
		check({9'h000, prot}, 10'h000);
		opt = 1'b1;
		nrst = 1'b0;
		repeat (6) @(negedge clock);
		nrst = 1'b1;
		repeat (3) @(negedge clock);
		check({9'h000, prot}, 10'h001);
		rd(a[1], 8'h00, 1'b1);
		cmd(OP_OPTION, 16'h0000, 8'h00, 1'b1, 2'd0);
		check({9'h000, prot}, 10'h000);
		stop_test();
	end
	initial begin
		#200_000;
		err_count++;
		stop_test();
	end
endmodule // tb
